// File: src/itec_pkg.sv
package itec_pkg;
	// Cycle timing
	localparam int unsigned   CLK_FREQ_HZ      = 25000000;
	localparam int unsigned   STATES_PER_CYCLE = 10;
	localparam int unsigned   OSC_PER_STATE    = 3;
	localparam int unsigned   OSC_PER_CYCLE    = STATES_PER_CYCLE * OSC_PER_STATE;
	localparam logic [4:0]    OSC_CNT_LAST     = 5'(OSC_PER_CYCLE - 1);
	localparam logic [4:0]    OSC_CNT_RST      = 5'h00;
	localparam logic [4:0]    PRE_RST          = 5'h00;
	localparam logic [4:0]    PRE_LAST         = 5'h1f;
	localparam logic [7:0]    COUNT_RST        = 8'h00;
	localparam logic [7:0]    COUNT_LAST       = 8'hff;
	localparam logic [10:0]   VECTOR_TIMER     = 11'h007;
	localparam logic [10:0]   VECTOR_EXT       = 11'h003;

	// Bus register map
	localparam logic [3:0]    ADR_STATUS       = 4'h0;
	localparam logic [3:0]    ADR_MASK         = 4'h4;
	localparam logic [3:0]    ADR_COUNT        = 4'h8;
	localparam logic [1:0]    IRQ_RST          = 2'h0;
	localparam int unsigned   IRQ_OVF_BIT      = 0;
	localparam int unsigned   IRQ_EDGE_BIT     = 1;

	typedef enum logic [1:0] {
		ITEC_IDLE  = 2'b00,
		ITEC_TIMER = 2'b01,
		ITEC_EVENT = 2'b10
	} itec_mode_e;

	typedef struct packed {
		logic       load_count;
		logic       read_count;
		logic       start_interval;
		logic       start_event;
		logic       halt_count;
		logic       branch_on_overflow_flag;
		logic       int_enable;
		logic       int_disable;
		logic       interrupt_return;
		logic       ext_int_req;
		logic [7:0] acc;
	} itec_cmd_s;
endpackage

// File: src/itec_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Instruction cycle is ten states of three oscillator periods each.
// - Load command copies the accumulator into the 8-bit count.
// - Start-timer clears prescaler, then advances it every thirty oscillator clocks.
// - Prescaler counts modulo 32; its wrap to zero advances the count.
// - Count rollover from FFH sets overflow flag and, if enabled, interrupt.
// - Each overflow-flag branch test clears the flag, taken or not, unless a rollover sets it in that same cycle.
// - Reset leaves overflow flag alone; software tests it once afterwards.
// - Read command returns count without disturbing timing or counting.
// - In event mode each event input rising edge advances the count.
// - Timer and event modes exclusive; latest start command picks mode.
// - Either mode starts or halts any time; halted count holds.
// - Taken timer interrupt vectors execution to location 7.
// - Simultaneous external and timer interrupts: external is served first.
// - After acceptance further interrupts ignored until interrupt return.
module itec_timer
	import itec_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	// Core command port
	input  wire itec_cmd_s   CMD,
	output logic [7:0]       RD_DATA,
	output logic             FLAG_TEST,
	output logic             TIMER_IRQ_REQ,
	output logic             INT_TAKE,
	output logic [10:0]      INT_VECTOR,
	// Event pin
	input  wire logic        EVENT_INPUT,
	// Wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             WB_ERR_O,
	// Interrupt
	output logic             IRQ
);
	logic [4:0]  osc_cnt_ff;
	logic        slot_tick;
	logic [4:0]  pre_ff;
	logic [7:0]  count_ff;
	logic        ovf_flag_ff;
	logic        tint_en_ff;
	logic        tint_pend_ff;
	logic        int_busy_ff;
	itec_mode_e  mode_ff;
	logic [2:0]  ev_sync_ff;
	logic        ev_rise;
	logic        count_step;
	logic        count_wrap;
	logic [1:0]  irq_stat_ff;
	logic [1:0]  irq_mask_ff;
	logic        wb_req;
	logic        wb_hit;

	// Oscillator slot divider, free running so command timing never drifts
	always_ff @(posedge CLK) begin
		if (SYS_RST || osc_cnt_ff == OSC_CNT_LAST) begin
			osc_cnt_ff <= OSC_CNT_RST;
		end else begin
			osc_cnt_ff <= osc_cnt_ff + 5'h01;
		end
	end
	assign slot_tick = (osc_cnt_ff == OSC_CNT_LAST);

	// Mode select, latest start wins
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			mode_ff <= ITEC_IDLE;
		end else if (CMD.start_interval) begin
			mode_ff <= ITEC_TIMER;
		end else if (CMD.start_event) begin
			mode_ff <= ITEC_EVENT;
		end else if (CMD.halt_count) begin
			mode_ff <= ITEC_IDLE;
		end
	end

	// Prescaler
	always_ff @(posedge CLK) begin
		if (SYS_RST || CMD.start_interval) begin
			pre_ff <= PRE_RST;
		end else if (mode_ff == ITEC_TIMER && slot_tick) begin
			pre_ff <= pre_ff + 5'h01;
		end
	end

	// Event synchroniser; stage 0 feeds only stage 1
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ev_sync_ff <= 3'h0;
		end else begin
			ev_sync_ff <= {ev_sync_ff[1:0], EVENT_INPUT};
		end
	end
	assign ev_rise = ev_sync_ff[1] & ~ev_sync_ff[2];

	assign count_step = (mode_ff == ITEC_TIMER && slot_tick && pre_ff == PRE_LAST)
		|| (mode_ff == ITEC_EVENT && ev_rise);
	assign count_wrap = count_step && count_ff == COUNT_LAST;

	// Count register; a load in the same cycle as a step wins
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			count_ff <= COUNT_RST;
		end else if (CMD.load_count) begin
			count_ff <= CMD.acc;
		end else if (count_step) begin
			count_ff <= count_ff + 8'h01;
		end
	end
	assign RD_DATA = count_ff;

	// Overflow flag: no reset by design, so software must test it once
	always_ff @(posedge CLK) begin
		if (count_wrap) begin
			ovf_flag_ff <= 1'b1;
		end else if (CMD.branch_on_overflow_flag) begin
			ovf_flag_ff <= 1'b0;
		end
	end
	assign FLAG_TEST = ovf_flag_ff;

	// Timer interrupt enable
	always_ff @(posedge CLK) begin
		if (SYS_RST || CMD.int_disable) begin
			tint_en_ff <= 1'b0;
		end else if (CMD.int_enable) begin
			tint_en_ff <= 1'b1;
		end
	end

	// Acceptance logic
	logic take_ext;
	logic take_tmr;
	assign take_ext = !int_busy_ff && CMD.ext_int_req;
	assign take_tmr = !int_busy_ff && !CMD.ext_int_req && tint_pend_ff;

	// Timer request level
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			tint_pend_ff <= 1'b0;
		end else if (count_wrap && tint_en_ff) begin
			tint_pend_ff <= 1'b1;
		end else if (take_tmr || CMD.int_disable) begin
			tint_pend_ff <= 1'b0;
		end
	end
	assign TIMER_IRQ_REQ = tint_pend_ff;

	always_ff @(posedge CLK) begin
		if (SYS_RST || CMD.interrupt_return) begin
			int_busy_ff <= 1'b0;
		end else if (take_ext || take_tmr) begin
			int_busy_ff <= 1'b1;
		end
	end
	assign INT_TAKE = take_ext || take_tmr;
	assign INT_VECTOR = take_tmr ? VECTOR_TIMER : (take_ext ? VECTOR_EXT : 11'h000);

	// Wishbone slave, one-cycle ack after one wait state
	assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
	assign wb_hit = WB_ADR_I == ADR_STATUS || WB_ADR_I == ADR_MASK || WB_ADR_I == ADR_COUNT;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			WB_ACK_O <= 1'b0;
			WB_ERR_O <= 1'b0;
			WB_DAT_O <= 32'h0;
		end else begin
			WB_ACK_O <= wb_req && wb_hit;
			WB_ERR_O <= wb_req && !wb_hit;
			if (wb_req && !WB_WE_I) begin
				if (WB_ADR_I == ADR_STATUS) begin
					WB_DAT_O <= {30'h0, irq_stat_ff};
				end else if (WB_ADR_I == ADR_MASK) begin
					WB_DAT_O <= {30'h0, irq_mask_ff};
				end else if (WB_ADR_I == ADR_COUNT) begin
					WB_DAT_O <= {23'h0, ovf_flag_ff, count_ff};
				end else begin
					WB_DAT_O <= 32'h0;
				end
			end
		end
	end

	// Sticky status; a new event beats a write-one clear
	logic       wr_stat;
	logic [1:0] ev_set;
	assign wr_stat = wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ADR_STATUS;
	assign ev_set = {ev_rise && mode_ff == ITEC_EVENT, count_wrap};
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			irq_stat_ff <= IRQ_RST;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~(wr_stat ? WB_DAT_I[1:0] : 2'h0)) | ev_set;
		end
	end
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			irq_mask_ff <= IRQ_RST;
		end else if (wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ADR_MASK) begin
			irq_mask_ff <= WB_DAT_I[1:0];
		end
	end
	assign IRQ = |(irq_stat_ff & irq_mask_ff);

	// Assertions
	sequence s_timer_run;
		mode_ff == ITEC_TIMER && !CMD.load_count && !CMD.start_interval;
	endsequence
	a_prescale_step: assert property (@(posedge CLK) disable iff (SYS_RST)
		(s_timer_run and (slot_tick && !CMD.halt_count && !CMD.start_event)) |=> pre_ff == $past(pre_ff) + 5'h01)
		else $error("prescaler did not advance on slot");
	a_prescale_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
		!slot_tick && !CMD.start_interval |=> pre_ff == $past(pre_ff))
		else $error("prescaler moved off slot");
	a_start_clears: assert property (@(posedge CLK) disable iff (SYS_RST)
		CMD.start_interval |=> pre_ff == PRE_RST && mode_ff == ITEC_TIMER)
		else $error("start timer did not clear prescaler");
	a_slot_period: assert property (@(posedge CLK) disable iff (SYS_RST)
		slot_tick |=> !slot_tick [*8])
		else $error("slot tick too frequent");
	a_load_count: assert property (@(posedge CLK) disable iff (SYS_RST)
		CMD.load_count |=> count_ff == $past(CMD.acc))
		else $error("load did not copy accumulator");
	a_event_count: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_ff == ITEC_EVENT && ev_rise && !CMD.load_count |=> count_ff == $past(count_ff) + 8'h01)
		else $error("event edge not counted");
	a_halt_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_ff == ITEC_IDLE && !CMD.load_count |=> count_ff == $past(count_ff))
		else $error("halted count changed");
	a_overflow_set: assert property (@(posedge CLK) disable iff (SYS_RST)
		count_wrap |=> ovf_flag_ff && count_ff == 8'h00 || $past(CMD.load_count))
		else $error("overflow not flagged");
	a_flag_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
		CMD.branch_on_overflow_flag && !count_wrap |=> !ovf_flag_ff)
		else $error("flag test did not clear flag");
	a_ext_first: assert property (@(posedge CLK) disable iff (SYS_RST)
		INT_TAKE && CMD.ext_int_req |-> INT_VECTOR == VECTOR_EXT)
		else $error("external not given priority");
	a_timer_vector: assert property (@(posedge CLK) disable iff (SYS_RST)
		take_tmr |-> INT_VECTOR == VECTOR_TIMER ##1 int_busy_ff && !tint_pend_ff)
		else $error("timer vector wrong");
	a_single_level: assert property (@(posedge CLK) disable iff (SYS_RST)
		int_busy_ff |-> !INT_TAKE)
		else $error("interrupt taken while busy");

	// Slot and prescaler timing
	a_slot_regular: assert property (@(posedge CLK) disable iff (SYS_RST)
		slot_tick |-> ##30 slot_tick)
		else $error("slot spacing is not thirty clocks");
	a_prescale_wrap: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_ff == ITEC_TIMER && slot_tick && pre_ff == PRE_LAST && !CMD.start_interval |=> pre_ff == PRE_RST)
		else $error("prescaler did not wrap to zero");
	a_prescale_idle: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_ff != ITEC_TIMER && !CMD.start_interval |=> pre_ff == $past(pre_ff))
		else $error("prescaler moved outside timer mode");

	// Count register stepping
	a_timer_step: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_ff == ITEC_TIMER && slot_tick && pre_ff == PRE_LAST && !CMD.load_count
		|=> count_ff == $past(count_ff) + 8'h01)
		else $error("prescaler wrap did not step count");
	a_timer_still: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_ff == ITEC_TIMER && !(slot_tick && pre_ff == PRE_LAST) && !CMD.load_count
		|=> count_ff == $past(count_ff))
		else $error("count stepped without prescaler wrap");
	a_event_still: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_ff == ITEC_EVENT && !ev_rise && !CMD.load_count |=> count_ff == $past(count_ff))
		else $error("count stepped without event edge");
	a_read_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
		CMD.read_count && !CMD.load_count && !count_step |=> count_ff == $past(count_ff))
		else $error("read disturbed the count");
	a_edge_single: assert property (@(posedge CLK) disable iff (SYS_RST)
		ev_rise |=> !ev_rise)
		else $error("one event edge seen twice");

	// Mode selection
	a_mode_event: assert property (@(posedge CLK) disable iff (SYS_RST)
		CMD.start_event && !CMD.start_interval |=> mode_ff == ITEC_EVENT)
		else $error("start event did not select event mode");
	a_mode_halt: assert property (@(posedge CLK) disable iff (SYS_RST)
		CMD.halt_count && !CMD.start_interval && !CMD.start_event |=> mode_ff == ITEC_IDLE)
		else $error("halt did not stop counting");
	a_edge_status: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_ff != ITEC_EVENT && !irq_stat_ff[IRQ_EDGE_BIT] |=> !irq_stat_ff[IRQ_EDGE_BIT])
		else $error("edge status set outside event mode");

	// Overflow and timer request
	a_status_ovf: assert property (@(posedge CLK) disable iff (SYS_RST)
		count_wrap |=> irq_stat_ff[IRQ_OVF_BIT])
		else $error("overflow status not set");
	a_irq_enabled: assert property (@(posedge CLK) disable iff (SYS_RST)
		count_wrap && tint_en_ff |=> tint_pend_ff)
		else $error("enabled overflow raised no request");
	a_irq_disabled: assert property (@(posedge CLK) disable iff (SYS_RST)
		!tint_en_ff && !tint_pend_ff |=> !tint_pend_ff)
		else $error("request raised while disabled");
	a_req_level: assert property (@(posedge CLK) disable iff (SYS_RST)
		tint_pend_ff && !take_tmr && !CMD.int_disable |=> tint_pend_ff)
		else $error("timer request dropped early");
	a_req_disable: assert property (@(posedge CLK) disable iff (SYS_RST)
		CMD.int_disable && !(count_wrap && tint_en_ff) |=> !tint_pend_ff && !tint_en_ff)
		else $error("disable left request standing");

	// Acceptance and priority
	a_timer_waits: assert property (@(posedge CLK) disable iff (SYS_RST)
		tint_pend_ff && CMD.ext_int_req && !int_busy_ff && !CMD.int_disable |=> tint_pend_ff)
		else $error("timer request lost to external");
	a_busy_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
		int_busy_ff && !CMD.interrupt_return |=> int_busy_ff)
		else $error("busy released without return");
	a_return_free: assert property (@(posedge CLK) disable iff (SYS_RST)
		CMD.interrupt_return |=> !int_busy_ff)
		else $error("return did not re-enable acceptance");
	a_no_source: assert property (@(posedge CLK) disable iff (SYS_RST)
		!tint_pend_ff && !CMD.ext_int_req |-> !INT_TAKE)
		else $error("interrupt taken with no request");
	a_vector_none: assert property (@(posedge CLK) disable iff (SYS_RST)
		!INT_TAKE |-> INT_VECTOR == 11'h000)
		else $error("vector shown without acceptance");

	// Register bus
	a_wb_answer: assert property (@(posedge CLK) disable iff (SYS_RST)
		wb_req && wb_hit |=> WB_ACK_O && !WB_ERR_O)
		else $error("mapped access not acknowledged");
	a_wb_error: assert property (@(posedge CLK) disable iff (SYS_RST)
		wb_req && !wb_hit |=> WB_ERR_O && !WB_ACK_O)
		else $error("unmapped access not refused");
	a_wb_ack_one: assert property (@(posedge CLK) disable iff (SYS_RST)
		WB_ACK_O || WB_ERR_O |=> !WB_ACK_O && !WB_ERR_O)
		else $error("bus answer held too long");
	a_mask_write: assert property (@(posedge CLK) disable iff (SYS_RST)
		wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ADR_MASK |=> irq_mask_ff == $past(WB_DAT_I[1:0]))
		else $error("mask write lost");
endmodule // itec_timer
`default_nettype wire

// File: dv/itec_evt_src.sv
`timescale 1ns/10ps
`default_nettype none
module itec_evt_src #(
	parameter int GAP = 400
) (
	// Clock
	input  wire logic CLK,
	// Event pin
	output logic      EVENT_INPUT
);
	initial EVENT_INPUT = 1'b0;

	// Edges stay far apart; the pin rests low between bursts
	task automatic burst(input int n);
		repeat (n) begin
			@(posedge CLK);
			EVENT_INPUT <= 1'b1;
			repeat (GAP / 2) @(posedge CLK);
			EVENT_INPUT <= 1'b0;
			repeat (GAP / 2) @(posedge CLK);
		end
	endtask
endmodule // itec_evt_src
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import itec_pkg::*;
	localparam int LD = 17, RDC = 16, ST = 15, SE = 14, HLT = 13, BR = 12, IEN = 11, IRET = 9;
	logic        clk, rst, evt, cyc, stb, we, ack, err, irq, flg, req, take, e;
	logic [3:0]  adr;
	logic [31:0] wdat, dato, q;
	logic [7:0]  rd;
	logic [10:0] vec;
	itec_cmd_s   cmd;
	int          n_errors, compares, i;

	itec_timer i_dut (.CLK(clk), .SYS_RST(rst), .CMD(cmd), .RD_DATA(rd), .FLAG_TEST(flg),
		.TIMER_IRQ_REQ(req), .INT_TAKE(take), .INT_VECTOR(vec), .EVENT_INPUT(evt), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
		.WB_DAT_O(dato), .WB_ACK_O(ack), .WB_ERR_O(err), .IRQ(irq));
	itec_evt_src i_src (.CLK(clk), .EVENT_INPUT(evt));

	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", s, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		if (n_errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// One-cycle command pulse; returns mid-cycle so results are settled
	task automatic pulse(input int k, input logic [7:0] a);
		@(posedge clk);
		cmd <= itec_cmd_s'((18'h1 << k) | {10'h0, a});
		@(posedge clk);
		cmd <= '0;
		@(negedge clk);
	endtask

	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
		do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
		q = dato;
		e = err;
		{cyc, stb} <= 2'h0;
	endtask

	task automatic t_load;
		pulse(LD, 8'h5a);
		chk("count", 32'(rd), 32'h5a);
		pulse(RDC, 8'h00);
		chk("count", 32'(rd), 32'h5a);
	endtask

	// Window brackets the 960-clock step without assuming the exact phase
	task automatic t_timer;
		pulse(LD, 8'hfe);
		pulse(IEN, 8'h00);
		pulse(ST, 8'h00);
		repeat (930) @(negedge clk);
		chk("count", 32'(rd), 32'hfe);
		repeat (60) @(negedge clk);
		chk("count", 32'(rd), 32'hff);
		for (i = 0; i < 1100 && take !== 1'b1; i++) @(negedge clk);
		chk("take", 32'(take), 32'h1);
		chk("request", 32'(req), 32'h1);
		chk("vector", 32'(vec), 32'h7);
		chk("count", 32'(rd), 32'h0);
		chk("flag", 32'(flg), 32'h1);
		pulse(IRET, 8'h00);
	endtask

	task automatic t_halt;
		pulse(HLT, 8'h00);
		repeat (1000) @(negedge clk);
		chk("count", 32'(rd), 32'h0);
		pulse(BR, 8'h00);
		chk("flag", 32'(flg), 32'h0);
	endtask

	// Burst outlasts one timer step, so leftover timer mode would show
	task automatic t_event;
		pulse(LD, 8'h10);
		pulse(SE, 8'h00);
		i_src.burst(3);
		repeat (8) @(negedge clk);
		chk("count", 32'(rd), 32'h13);
	endtask

	// External request alone is taken at once, then locks out a second one
	task automatic t_ext;
		@(posedge clk);
		cmd <= itec_cmd_s'(18'h100);
		@(negedge clk);
		chk("take", 32'(take), 32'h1);
		chk("vector", 32'(vec), 32'(VECTOR_EXT));
		@(negedge clk);
		chk("take", 32'(take), 32'h0);
		@(posedge clk);
		cmd <= '0;
		pulse(IRET, 8'h00);
	endtask

	task automatic t_regs;
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("status", q, 32'h3);
		chk("irq", 32'(irq), 32'h0);
		wb(1'b1, ADR_MASK, 32'h1);
		@(negedge clk);
		chk("irq", 32'(irq), 32'h1);
		wb(1'b1, ADR_STATUS, 32'h1);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("status", q, 32'h2);
		chk("irq", 32'(irq), 32'h0);
		wb(1'b0, ADR_COUNT, 32'h0);
		chk("countreg", q, 32'h13);
		wb(1'b0, 4'hc, 32'h0);
		chk("unmapped", 32'(e), 32'h1);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (8000) @(posedge clk);
		n_errors++;
		tally_and_finish;
	end

	initial begin
		rst = 1'b1;
		cmd = '0;
		{cyc, stb, we, adr, wdat} = '0;
		n_errors = 0;
		compares = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// Flag is unknown out of reset until software tests it once
		pulse(BR, 8'h00);
		chk("flag", 32'(flg), 32'h0);
		t_load;
		t_timer;
		t_halt;
		t_event;
		t_regs;
		t_ext;
		tally_and_finish;
	end
endmodule // tb
`default_nettype wire
